// *** verilog/vpt_translate.sv ***
/*
 vpt_translate: memory unit translation path with hardware page
 table, refill, quadword data cache, page fault and error flags.
 Assumes one word memory port with held request and one-cycle ack,
 and an execution unit that holds its request until answered.
*/
`timescale 1ns/10ps
module vpt_translate (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// request from the execution unit
	input wire logic req_valid_in,
	input wire vpt_pkg::vpt_req_t req_in,
	output logic memory_response_out,
	output logic [vpt_pkg::WD_W-1:0] cache_data_out,
	output logic pf_hold_out,
	output logic [vpt_pkg::WD_W-1:0] fault_word_out,
	// configuration
	input wire logic [vpt_pkg::PG_W-1:0] user_base_in,
	input wire logic [vpt_pkg::PG_W-1:0] exec_base_in,
	input wire logic pt_flush_in,
	// core memory port
	output vpt_pkg::vpt_mem_cmd_t mem_cmd_out,
	input wire logic mem_ack_in,
	input wire logic [vpt_pkg::WD_W-1:0] mem_rdata_in,
	input wire logic mem_par_err_in,
	// error reporting
	input wire logic [vpt_pkg::MERR_W-1:0] mem_err_in,
	input wire logic [vpt_pkg::FLAG_W-1:0] err_clr_in,
	output logic buffer_parity_fault_out,
	output logic processor_parity_flag_out,
	output logic [vpt_pkg::FLAG_W-1:0] processor_error_flags_out,
	output logic err_irq_out,
	// pointer walk
	input wire logic walk_start_in,
	input wire logic walk_user_in,
	input wire logic [vpt_pkg::SEC_W-1:0] walk_sect_in,
	input wire logic [vpt_pkg::VPN_W-1:0] walk_vpn_in,
	input wire logic [vpt_pkg::PA_W-1:0] user_process_table_in,
	input wire logic [vpt_pkg::PA_W-1:0] exec_process_table_in,
	input wire logic [vpt_pkg::PA_W-1:0] shared_table_base_in,
	input wire logic pi_pending_in,
	output vpt_pkg::vpt_mem_cmd_t walk_cmd_out,
	input wire logic walk_ack_in,
	input wire logic [vpt_pkg::WD_W-1:0] walk_rdata_in,
	output logic walk_busy_out,
	output logic walk_done_out,
	output logic walk_fault_out,
	output logic [vpt_pkg::PG_W-1:0] walk_page_out,
	output logic [vpt_pkg::ACC_W-1:0] walk_acc_out
);
	////////////////////////////////////////////////////////////////////////////

	vpt_pkg::vpt_top_t s_r;
	vpt_pkg::vpt_top_t s_nxt;

	// hardware page table: pairs of half-word entries
	logic [vpt_pkg::WD_W-1:0] pt_pair [vpt_pkg::PAIR_N];
	logic [vpt_pkg::PAIR_N-1:0] pt_valid_r;
	logic pt_we;
	logic [7:0] pt_wa;

	// data cache: one quadword per line
	logic [vpt_pkg::WD_W-1:0] cl_data [vpt_pkg::CL_N*4];
	logic [15:0] cl_tag [vpt_pkg::CL_N];
	logic cl_we;
	logic [5:0] cl_wa;
	logic [vpt_pkg::WD_W-1:0] cl_wd;
	logic tag_we;

	// decoded address pieces
	logic [vpt_pkg::VPN_W-1:0] vpn;
	logic [vpt_pkg::HW_W-1:0] look_hw;
	logic look_ok;
	logic [3:0] cidx;
	logic [15:0] ctag;
	logic chit;
	logic [vpt_pkg::WD_W-1:0] cword;
	logic [vpt_pkg::PG_W-1:0] base;
	logic [vpt_pkg::FLAG_W-1:0] flag_set;

	////////////////////////////////////////////////////////////////////////////
	// lookups are combinational so a hit answers in two cycles

	// page table lookup by virtual page
	always_comb begin
		vpn = s_r.req.va[17:9];
		look_hw = vpn[0] ? pt_pair[vpn[8:1]][17:0] : pt_pair[vpn[8:1]][35:18];
		look_ok = pt_valid_r[vpn[8:1]] && look_hw[vpt_pkg::HW_ACC] &&
			(!s_r.req.we || look_hw[vpt_pkg::HW_WR]);
		base = s_r.req.user ? user_base_in : exec_base_in;
	end

	// cache lookup by quadword address
	always_comb begin
		cidx = s_r.pa[5:2];
		ctag = s_r.pa[21:6];
		chit = s_r.cl_valid[cidx] && (cl_tag[cidx] == ctag);
		cword = cl_data[{cidx, s_r.pa[1:0]}]; // word in quadword
	end

	////////////////////////////////////////////////////////////////////////////

	// next state of the translation sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.resp = 1'h0;
		s_nxt.par_fault = 1'h0;
		pt_we = 1'h0;
		pt_wa = {vpn[8:3], s_r.wcnt};
		cl_we = 1'h0;
		cl_wa = {cidx, s_r.wcnt};
		cl_wd = mem_rdata_in;
		tag_we = 1'h0;
		flag_set = {1'h0, mem_err_in};
		case (s_r.st)
			vpt_pkg::S_IDLE: begin
				// no fault hold standing, and not the request just answered: the
				// unit still shows it while it samples the response pulse
				if (req_valid_in && !s_r.pf_hold && !s_r.resp) begin
					s_nxt.req = req_in;
					s_nxt.st = vpt_pkg::S_LOOK;
				end
			end
			vpt_pkg::S_LOOK: begin
				if (look_ok) begin
					s_nxt.pa = {look_hw[vpt_pkg::PG_W-1:0], s_r.req.va[8:0]};
					s_nxt.st = vpt_pkg::S_CACHE;
				end else begin
					// miss or denied entry: refill the quadword of half-words
					s_nxt.cmd = '{1'h1, 1'h0, {base, 1'h0, vpn[8:3], 2'h0}, 36'h0};
					s_nxt.wcnt = 2'h0;
					s_nxt.st = vpt_pkg::S_REFILL;
				end
			end
			vpt_pkg::S_REFILL: begin
				if (mem_ack_in) begin
					pt_we = 1'h1; // both half-words, whatever the access bit
					if (s_r.wcnt == vpn[2:1]) begin
						s_nxt.hw = vpn[0] ? mem_rdata_in[17:0] : mem_rdata_in[35:18];
					end
					if (s_r.wcnt == 2'h3) begin
						s_nxt.cmd.req = 1'h0;
						s_nxt.st = vpt_pkg::S_CHECK;
					end else begin
						s_nxt.wcnt = 2'(s_r.wcnt + 2'h1);
						s_nxt.cmd.addr = vpt_pkg::PA_W'(s_r.cmd.addr + 22'h1);
					end
				end
			end
			vpt_pkg::S_CHECK: begin
				if (!s_r.hw[vpt_pkg::HW_ACC] || (s_r.req.we && !s_r.hw[vpt_pkg::HW_WR])) begin
					s_nxt.pf_hold = 1'h1;
					s_nxt.fsent = 1'h0;
					s_nxt.fword = {s_r.req.user, s_r.req.we,
						s_r.hw[vpt_pkg::HW_ACC] ? vpt_pkg::FC_WRITE : vpt_pkg::FC_NOACC,
						9'h000, s_r.req.va};
					s_nxt.st = vpt_pkg::S_FAULT;
				end else begin
					s_nxt.pa = {s_r.hw[vpt_pkg::PG_W-1:0], s_r.req.va[8:0]};
					s_nxt.st = vpt_pkg::S_CACHE;
				end
			end
			vpt_pkg::S_CACHE: begin
				if (s_r.req.we) begin
					// write-through; a resident word is updated in place
					s_nxt.cmd = '{1'h1, 1'h1, s_r.pa, s_r.req.wdata};
					cl_we = chit;
					cl_wa = {cidx, s_r.pa[1:0]};
					cl_wd = s_r.req.wdata;
					s_nxt.st = vpt_pkg::S_WRITE;
				end else if (chit) begin
					s_nxt.data = cword;
					s_nxt.resp = 1'h1;
					s_nxt.st = vpt_pkg::S_IDLE;
				end else begin
					s_nxt.cmd = '{1'h1, 1'h0, {s_r.pa[21:2], 2'h0}, 36'h0};
					s_nxt.wcnt = 2'h0;
					s_nxt.par_pend = 1'h0;
					s_nxt.cl_valid[cidx] = 1'h0; // line is torn while it fills
					s_nxt.st = vpt_pkg::S_FILL;
				end
			end
			vpt_pkg::S_FILL: begin
				if (mem_ack_in) begin
					cl_we = 1'h1;
					if (mem_par_err_in) begin
						s_nxt.par_pend = 1'h1;
					end
					if (s_r.wcnt == s_r.pa[1:0]) begin
						s_nxt.data = mem_rdata_in;
					end
					if (s_r.wcnt == 2'h3) begin
						s_nxt.cmd.req = 1'h0;
						tag_we = 1'h1;
						s_nxt.cl_valid[cidx] = 1'h1;
						s_nxt.resp = 1'h1;
						// parity fault is timed from this response
						if (s_r.par_pend || mem_par_err_in) begin
							s_nxt.par_cnt = vpt_pkg::PAR_DELAY;
						end
						s_nxt.st = vpt_pkg::S_IDLE;
					end else begin
						s_nxt.wcnt = 2'(s_r.wcnt + 2'h1);
						s_nxt.cmd.addr = vpt_pkg::PA_W'(s_r.cmd.addr + 22'h1);
					end
				end
			end
			vpt_pkg::S_WRITE: begin
				if (mem_ack_in) begin
					s_nxt.cmd.req = 1'h0;
					s_nxt.resp = 1'h1;
					s_nxt.st = vpt_pkg::S_IDLE;
				end
			end
			vpt_pkg::S_FAULT: begin
				// hold first, then a response with no data
				if (!s_r.fsent) begin
					s_nxt.resp = 1'h1;
					s_nxt.fsent = 1'h1;
				end else if (!req_valid_in) begin
					// relies on the request staying up until answered
					s_nxt.pf_hold = 1'h0;
					s_nxt.st = vpt_pkg::S_IDLE;
				end
			end
			default: s_nxt.st = vpt_pkg::S_IDLE;
		endcase

		// delayed parity fault pulse and sticky flags, set beats clear
		if (s_r.par_cnt != 3'h0) begin
			s_nxt.par_cnt = 3'(s_r.par_cnt - 3'h1);
			if (s_r.par_cnt == 3'h1) begin
				s_nxt.par_fault = 1'h1;
				flag_set[vpt_pkg::PAR_IDX] = 1'h1;
			end
		end
		s_nxt.flags = (s_r.flags & ~err_clr_in) | flag_set;
		s_nxt.irq = |s_nxt.flags;
	end

	////////////////////////////////////////////////////////////////////////////

	// state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '{st: vpt_pkg::S_IDLE, flags: vpt_pkg::FLAGS_RST, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// page table valid bits; a flush drops every translation
	genvar gi;
	generate
		for (gi = 0; gi < vpt_pkg::PAIR_N; gi++) begin : g_ptv
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					pt_valid_r[gi] <= 1'h0;
				end else if (pt_flush_in) begin
					pt_valid_r[gi] <= 1'h0;
				end else if (pt_we && pt_wa == 8'(gi)) begin
					pt_valid_r[gi] <= 1'h1;
				end
			end
		end
	endgenerate

	// memories carry no reset; validity lives in the flags above
	always_ff @(posedge core_clk_in) begin
		if (pt_we) begin
			pt_pair[pt_wa] <= mem_rdata_in;
		end
		if (cl_we) begin
			cl_data[cl_wa] <= cl_wd;
		end
		if (tag_we) begin
			cl_tag[cidx] <= ctag;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// pointer walk through the process and shared tables
	vpt_ptr_walk u_walk (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.start_in(walk_start_in),
		.user_in(walk_user_in),
		.sect_in(walk_sect_in),
		.vpn_in(walk_vpn_in),
		.upt_base_in(user_process_table_in),
		.ept_base_in(exec_process_table_in),
		.sbr_in(shared_table_base_in),
		.pi_pending_in(pi_pending_in),
		.mem_ack_in(walk_ack_in),
		.mem_rdata_in(walk_rdata_in),
		.mem_cmd_out(walk_cmd_out),
		.busy_out(walk_busy_out),
		.done_out(walk_done_out),
		.fault_out(walk_fault_out),
		.page_out(walk_page_out),
		.acc_out(walk_acc_out)
	);

	////////////////////////////////////////////////////////////////////////////

	// all outputs straight from the state register
	assign memory_response_out = s_r.resp;
	assign cache_data_out = s_r.data;
	assign pf_hold_out = s_r.pf_hold;
	assign fault_word_out = s_r.fword;
	assign mem_cmd_out = s_r.cmd;
	assign buffer_parity_fault_out = s_r.par_fault;
	assign processor_parity_flag_out = s_r.flags[vpt_pkg::PAR_IDX];
	assign processor_error_flags_out = s_r.flags;
	assign err_irq_out = s_r.irq;
endmodule : vpt_translate

// *** verilog/vpt_pkg.sv ***
/*
 vpt_pkg: constants, states and carrier types of the virtual page
 translation block. Assumes 36-bit words with bit 35 as the msb.
*/
package vpt_pkg;
	// address geometry
	localparam int VA_W = 23;
	localparam int PA_W = 22;
	localparam int WD_W = 36;
	localparam int PG_W = 13;
	localparam int VPN_W = 9;
	localparam int SEC_W = 5;
	localparam int PAIR_N = 256; // half-word pairs, 512 entries
	localparam int CL_N = 16; // cache lines, one quadword each
	// use bits inside a half-word entry
	localparam int HW_W = 18;
	localparam int HW_ACC = 17;
	localparam int HW_WR = 15;
	// page pointer fields
	localparam int PTR_TYP_HI = 35;
	localparam int PTR_ACC_HI = 32;
	localparam int PTR_PN_HI = 26;
	localparam int PTR_IDX_W = 18;
	localparam int ACC_W = 6;
	localparam logic [2:0] PTR_NONE = 3'h0;
	localparam logic [2:0] PTR_IMM = 3'h1;
	localparam logic [2:0] PTR_SHR = 3'h2;
	localparam logic [2:0] PTR_IND = 3'h3;
	// errors and fault codes
	localparam int MERR_W = 4;
	localparam int FLAG_W = 5;
	localparam int PAR_IDX = 4;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [2:0] PAR_DELAY = 3'h5;
	localparam logic [1:0] FC_NOACC = 2'h1;
	localparam logic [1:0] FC_WRITE = 2'h2;
	localparam logic [1:0] RET_PTR = 2'h0;
	localparam logic [1:0] RET_SHR = 2'h1;
	localparam logic [1:0] RET_IND = 2'h2;

	typedef enum logic [7:0] {S_IDLE = 8'h01, S_LOOK = 8'h02, S_REFILL = 8'h04,
		S_CHECK = 8'h08, S_CACHE = 8'h10, S_FILL = 8'h20, S_WRITE = 8'h40,
		S_FAULT = 8'h80} vpt_st_t;
	typedef enum logic [3:0] {W_IDLE = 4'h1, W_RD = 4'h2, W_INTERP = 4'h4,
		W_HOLD = 4'h8} vpt_wst_t;
	typedef struct packed {logic we; logic user; logic [VA_W-1:0] va;
		logic [WD_W-1:0] wdata;} vpt_req_t;
	typedef struct packed {logic req; logic we; logic [PA_W-1:0] addr;
		logic [WD_W-1:0] wdata;} vpt_mem_cmd_t;
	typedef struct packed {vpt_st_t st; vpt_req_t req; vpt_mem_cmd_t cmd;
		logic [1:0] wcnt; logic [HW_W-1:0] hw; logic [PA_W-1:0] pa; logic resp;
		logic [WD_W-1:0] data; logic pf_hold; logic fsent; logic [WD_W-1:0] fword;
		logic par_pend; logic [2:0] par_cnt; logic par_fault;
		logic [FLAG_W-1:0] flags; logic irq; logic [CL_N-1:0] cl_valid;} vpt_top_t;
	typedef struct packed {vpt_wst_t st; logic [1:0] ret; vpt_mem_cmd_t cmd;
		logic lvl; logic [WD_W-1:0] ptr; logic [ACC_W-1:0] acc;
		logic [VPN_W-1:0] ipn; logic [PG_W-1:0] page; logic done; logic fault;
		logic busy; logic user; logic [SEC_W-1:0] sect;
		logic [VPN_W-1:0] vpn;} vpt_walk_t;
endpackage : vpt_pkg

// *** verilog/vpt_ptr_walk.sv ***
/*
 vpt_ptr_walk: section and page pointer interpretation walk.
 Assumes a word memory port that answers each held request with a
 one-cycle ack carrying the read word.
*/
`timescale 1ns/10ps
module vpt_ptr_walk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic user_in,
	input wire logic [vpt_pkg::SEC_W-1:0] sect_in,
	input wire logic [vpt_pkg::VPN_W-1:0] vpn_in,
	input wire logic [vpt_pkg::PA_W-1:0] upt_base_in,
	input wire logic [vpt_pkg::PA_W-1:0] ept_base_in,
	input wire logic [vpt_pkg::PA_W-1:0] sbr_in,
	input wire logic pi_pending_in,
	input wire logic mem_ack_in,
	input wire logic [vpt_pkg::WD_W-1:0] mem_rdata_in,
	output vpt_pkg::vpt_mem_cmd_t mem_cmd_out,
	output logic busy_out,
	output logic done_out,
	output logic fault_out,
	output logic [vpt_pkg::PG_W-1:0] page_out,
	output logic [vpt_pkg::ACC_W-1:0] acc_out
);
	vpt_pkg::vpt_walk_t s_r;
	vpt_pkg::vpt_walk_t s_nxt;
	logic res_v;
	logic [vpt_pkg::PG_W-1:0] res_pg;
	logic [2:0] ptyp;
	logic [vpt_pkg::PA_W-1:0] tbase;

	// walk sequencer; a resolved page feeds the page stage or finishes
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'h0;
		res_v = 1'h0;
		res_pg = s_r.ptr[vpt_pkg::PG_W-1:0];
		ptyp = s_r.ptr[vpt_pkg::PTR_TYP_HI -: 3];
		tbase = s_r.user ? upt_base_in : ept_base_in;
		case (s_r.st)
			vpt_pkg::W_IDLE: begin
				if (start_in) begin
					s_nxt.user = user_in;
					s_nxt.sect = sect_in;
					s_nxt.vpn = vpn_in;
					s_nxt.busy = 1'h1;
					s_nxt.fault = 1'h0;
					s_nxt.st = vpt_pkg::W_HOLD; // restart path issues the first read
				end
			end
			vpt_pkg::W_RD: begin
				if (mem_ack_in) begin
					s_nxt.cmd.req = 1'h0;
					s_nxt.st = vpt_pkg::W_INTERP;
					if (s_r.ret == vpt_pkg::RET_PTR) begin
						s_nxt.ptr = mem_rdata_in;
					end else if (s_r.ret == vpt_pkg::RET_SHR) begin
						res_v = 1'h1;
						res_pg = mem_rdata_in[vpt_pkg::PG_W-1:0];
					end else begin
						// indirect: new pointer picked by page number
						s_nxt.cmd = '{1'h1, 1'h0, {mem_rdata_in[vpt_pkg::PG_W-1:0], s_r.ipn},
							36'h0};
						s_nxt.ret = vpt_pkg::RET_PTR;
						s_nxt.st = vpt_pkg::W_RD;
					end
				end
			end
			vpt_pkg::W_INTERP: begin
				if (pi_pending_in) begin
					s_nxt.st = vpt_pkg::W_HOLD; // abandon chain
				end else begin
					s_nxt.acc = s_r.acc & s_r.ptr[vpt_pkg::PTR_ACC_HI -: vpt_pkg::ACC_W];
					s_nxt.ipn = s_r.ptr[vpt_pkg::PTR_PN_HI -: vpt_pkg::VPN_W];
					case (ptyp)
						vpt_pkg::PTR_IMM: res_v = 1'h1;
						vpt_pkg::PTR_SHR, vpt_pkg::PTR_IND: begin
							s_nxt.cmd = '{1'h1, 1'h0, vpt_pkg::PA_W'(sbr_in +
								{4'h0, s_r.ptr[vpt_pkg::PTR_IDX_W-1:0]}), 36'h0};
							s_nxt.ret = (ptyp == vpt_pkg::PTR_SHR) ? vpt_pkg::RET_SHR : vpt_pkg::RET_IND;
							s_nxt.st = vpt_pkg::W_RD;
						end
						default: begin
							// no access or reserved code ends the walk
							s_nxt.fault = 1'h1;
							s_nxt.done = 1'h1;
							s_nxt.busy = 1'h0;
							s_nxt.st = vpt_pkg::W_IDLE;
						end
					endcase
				end
			end
			vpt_pkg::W_HOLD: begin
				if (!pi_pending_in) begin
					// start over from the section pointer
					s_nxt.lvl = 1'h0;
					s_nxt.acc = 6'h3f;
					s_nxt.cmd = '{1'h1, 1'h0, vpt_pkg::PA_W'(tbase + {17'h0, s_r.sect}), 36'h0};
					s_nxt.ret = vpt_pkg::RET_PTR;
					s_nxt.st = vpt_pkg::W_RD;
				end
			end
			default: s_nxt.st = vpt_pkg::W_IDLE;
		endcase
		// section result is the page table of the whole section
		if (res_v) begin
			if (!s_r.lvl) begin
				s_nxt.lvl = 1'h1;
				s_nxt.cmd = '{1'h1, 1'h0, {res_pg, s_r.vpn}, 36'h0};
				s_nxt.ret = vpt_pkg::RET_PTR;
				s_nxt.st = vpt_pkg::W_RD;
			end else begin
				s_nxt.page = res_pg;
				s_nxt.done = 1'h1;
				s_nxt.busy = 1'h0;
				s_nxt.st = vpt_pkg::W_IDLE;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '{st: vpt_pkg::W_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_cmd_out = s_r.cmd;
	assign busy_out = s_r.busy;
	assign done_out = s_r.done;
	assign fault_out = s_r.fault;
	assign page_out = s_r.page;
	assign acc_out = s_r.acc;
endmodule : vpt_ptr_walk

// *** sim/vpt_translate_monitor.sv ***
/*
 vpt_translate_monitor: port assertions of the translation block.
 Assumes a bind onto vpt_translate with a single clock domain.
*/
`timescale 1ns/10ps
module vpt_translate_monitor (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire vpt_pkg::vpt_req_t req_in,
	input wire logic memory_response_out,
	input wire logic pf_hold_out,
	input wire logic [vpt_pkg::WD_W-1:0] fault_word_out,
	input wire vpt_pkg::vpt_mem_cmd_t mem_cmd_out,
	input wire logic mem_ack_in,
	input wire logic [vpt_pkg::MERR_W-1:0] mem_err_in,
	input wire logic buffer_parity_fault_out,
	input wire logic processor_parity_flag_out,
	input wire logic [vpt_pkg::FLAG_W-1:0] processor_error_flags_out,
	input wire logic err_irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////
	// fault: hold rises, one response follows
	sequence pf_start; $rose(pf_hold_out); endsequence
	sequence pf_answer; ##1 memory_response_out; endsequence
	fault_resp_a: assert property (pf_start |-> pf_answer)
		else $error("fault hold without response");
	fault_kept_a: assert property (pf_hold_out && req_valid_in |=> pf_hold_out)
		else $error("fault hold dropped early");
	fault_word_a: assert property (pf_start |-> fault_word_out[22:0] == req_in.va)
		else $error("fault word lacks address");
	// parity report lags the response by exactly five ticks
	parity_delay_a: assert property (buffer_parity_fault_out |-> $past(memory_response_out, 5))
		else $error("parity fault at wrong time");
	parity_flag_a: assert property (buffer_parity_fault_out |-> processor_parity_flag_out)
		else $error("parity flag not set");
	err_set_a: assert property ((|mem_err_in) |=>
		(processor_error_flags_out[3:0] & $past(mem_err_in)) == $past(mem_err_in))
		else $error("error flag not set");
	// interrupt request is registered together with the flags
	irq_follow_a: assert property (1'b1 |-> err_irq_out == (|processor_error_flags_out))
		else $error("interrupt not following flags");
	// memory request must not move before it is taken
	mem_hold_a: assert property (mem_cmd_out.req && !mem_ack_in |=> $stable(mem_cmd_out))
		else $error("memory request changed early");
	write_addr_a: assert property (mem_cmd_out.req && mem_cmd_out.we |->
		mem_cmd_out.addr[8:0] == req_in.va[8:0] && mem_cmd_out.wdata == req_in.wdata)
		else $error("write address or data wrong");
endmodule : vpt_translate_monitor

// *** sim/vpt_eu_model.sv ***
/*
 vpt_eu_model: execution unit side, one reference at a time.
 Assumes go_in is driven away from the rising edge.
*/
`timescale 1ns/10ps
module vpt_eu_model (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire vpt_pkg::vpt_req_t op_in,
	input wire logic memory_response_in,
	input wire logic pf_hold_in,
	input wire logic [vpt_pkg::WD_W-1:0] cache_data_in,
	output logic req_valid_out,
	output vpt_pkg::vpt_req_t req_out,
	output logic [10:0] cs_addr_out,
	output logic [vpt_pkg::WD_W-1:0] data_out
);
	// no advance until answered; fault vectors the sequencer
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_valid_out <= 1'b0;
			req_out <= '0;
			cs_addr_out <= 11'h000;
			data_out <= '0;
		end else begin
			if (req_valid_out && memory_response_in) begin
				req_valid_out <= 1'b0;
				data_out <= cache_data_in;
			end else if (go_in && !req_valid_out) begin
				req_valid_out <= 1'b1;
				req_out <= op_in;
				cs_addr_out <= 11'h000;
			end
			if (pf_hold_in)
				cs_addr_out <= 11'h3ff;
		end
	end
endmodule : vpt_eu_model

// *** sim/test_vpt_translate.sv ***
/*
 test_vpt_translate: directed bench for translation, faults, errors, walk.
 Assumes the memory ports answer held requests with a one-cycle ack.
*/
`timescale 1ns/10ps
module test_vpt_translate;
	logic core_clk_in, rst_n_in, req_valid_in, pf_hold_out, memory_response_out;
	logic mem_ack_in, mem_par_err_in, buffer_parity_fault_out, processor_parity_flag_out;
	logic err_irq_out, walk_start_in, walk_user_in, walk_ack_in, walk_busy_out;
	logic walk_done_out, walk_fault_out, go, slow, par_inj, pi;
	vpt_pkg::vpt_req_t req_in, op;
	vpt_pkg::vpt_mem_cmd_t mem_cmd_out, walk_cmd_out;
	logic [35:0] cache_data_out, fault_word_out, mem_rdata_in, walk_rdata_in, eu_data;
	logic [12:0] user_base_in, walk_page_out;
	logic [3:0] mem_err_in;
	logic [4:0] err_clr_in, processor_error_flags_out, walk_sect_in;
	logic [8:0] walk_vpn_in;
	logic [21:0] user_process_table_in;
	logic [5:0] walk_acc_out;
	logic [10:0] cs_addr;
	int compares, fail_count, acks, cyc;
	logic [35:0] mem [logic [21:0]];
	////////////////////////////////////////
	vpt_translate i_vpt_translate (.core_clk_in, .rst_n_in, .req_valid_in, .req_in,
		.memory_response_out, .cache_data_out, .pf_hold_out, .fault_word_out, .user_base_in,
		.exec_base_in(13'h0000), .pt_flush_in(1'b0), .mem_cmd_out, .mem_ack_in, .mem_rdata_in,
		.mem_par_err_in, .mem_err_in, .err_clr_in, .buffer_parity_fault_out,
		.processor_parity_flag_out, .processor_error_flags_out, .err_irq_out, .walk_start_in,
		.walk_user_in, .walk_sect_in, .walk_vpn_in, .user_process_table_in,
		.exec_process_table_in(22'h000000), .shared_table_base_in(22'h002000),
		.pi_pending_in(pi), .walk_cmd_out, .walk_ack_in, .walk_rdata_in, .walk_busy_out,
		.walk_done_out, .walk_fault_out, .walk_page_out, .walk_acc_out);
	vpt_eu_model i_vpt_eu_model (.core_clk_in, .rst_n_in, .go_in(go), .op_in(op),
		.memory_response_in(memory_response_out), .pf_hold_in(pf_hold_out),
		.cache_data_in(cache_data_out), .req_valid_out(req_valid_in), .req_out(req_in),
		.cs_addr_out(cs_addr), .data_out(eu_data));
	////////////////////////////////////////
	function automatic logic [35:0] rd(input logic [21:0] a);
		return mem.exists(a) ? mem[a] : {14'h0c3a, a};
	endfunction : rd
	// memory answers on the falling edge; released data is scrambled
	always @(negedge core_clk_in) begin
		mem_ack_in <= mem_cmd_out.req && !(slow && mem_ack_in);
		mem_par_err_in <= mem_cmd_out.req && par_inj;
		mem_rdata_in <= mem_cmd_out.req ? rd(mem_cmd_out.addr) : ~mem_rdata_in;
		if (mem_cmd_out.req && mem_cmd_out.we && !(slow && mem_ack_in))
			mem[mem_cmd_out.addr] = mem_cmd_out.wdata;
		walk_ack_in <= walk_cmd_out.req;
		walk_rdata_in <= walk_cmd_out.req ? rd(walk_cmd_out.addr) : ~walk_rdata_in;
	end
	always @(posedge core_clk_in) begin
		cyc++;
		// one counter serves both ports; accesses and walks never overlap
		if ((mem_cmd_out.req && mem_ack_in) || (walk_cmd_out.req && walk_ack_in))
			acks++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	////////////////////////////////////////
	task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one reference through the execution unit model
	task automatic access(input logic we, input logic [22:0] va, input logic [35:0] wd);
		int n;
		@(negedge core_clk_in);
		op = '{we: we, user: 1'b1, va: va, wdata: wd};
		go = 1'b1;
		acks = 0;
		@(negedge core_clk_in);
		go = 1'b0;
		n = 0;
		while ((req_valid_in !== 1'b0 || pf_hold_out !== 1'b0) && n < 500) begin
			@(negedge core_clk_in);
			n++;
		end
	endtask : access
	task automatic walk(input logic [4:0] s, input logic [12:0] pg, input logic [5:0] ac,
		input logic ft, input logic ph);
		int n;
		@(negedge core_clk_in);
		walk_sect_in = s;
		walk_start_in = 1'b1;
		acks = 0;
		@(negedge core_clk_in);
		walk_start_in = 1'b0;
		n = 0;
		while (walk_done_out !== 1'b1 && n < 200) begin
			@(negedge core_clk_in);
			n++;
			// with ph the interrupt lands on the first pointer decode
			pi = ph && n > 1 && n < 6;
		end
		check("walk fault", {35'h0, ft}, {35'h0, walk_fault_out});
		check("walk busy", 36'h0, {35'h0, walk_busy_out});
		if (!ft) begin
			check("walk page", {23'h0, pg}, {23'h0, walk_page_out});
			check("walk access", {30'h0, ac}, {30'h0, walk_acc_out});
		end
	endtask : walk
	task automatic summarize();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	////////////////////////////////////////
	initial begin
		{rst_n_in, go, slow, par_inj, pi, walk_start_in, walk_user_in} = 7'h01;
		{mem_ack_in, mem_par_err_in, walk_ack_in, mem_err_in, err_clr_in} = '0;
		{mem_rdata_in, walk_rdata_in, walk_sect_in} = '0;
		op = '0;
		user_base_in = 13'h0100;
		user_process_table_in = 22'h001000;
		walk_vpn_in = 9'h012;
		mem[22'h020002] = {18'h200b4, 18'h280a5};
		mem[22'h020008] = 36'h000000000;
		mem[22'h001003] = {3'h1, 6'h3f, 14'h0, 13'h0777};
		mem[{13'h0777, 9'h012}] = {3'h1, 6'h15, 14'h0, 13'h0abc};
		mem[22'h001004] = {3'h2, 6'h3f, 9'h0, 18'h00010};
		mem[22'h002010] = {23'h0, 13'h0555};
		mem[{13'h0555, 9'h012}] = {3'h1, 6'h0f, 14'h0, 13'h0222};
		mem[22'h001005] = {3'h5, 33'h0};
		mem[22'h001006] = {3'h3, 6'h3e, 9'h00a, 18'h00020};
		mem[22'h002020] = {23'h0, 13'h0444};
		mem[{13'h0444, 9'h00a}] = {3'h1, 6'h3f, 14'h0, 13'h0777};
		mem[22'h000003] = {3'h1, 6'h3f, 14'h0, 13'h0555};
		repeat (3) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		access(1'b0, 23'h000a03, '0);
		check("miss data", {14'h0c3a, 22'h014a03}, eu_data);
		check("miss acks", 36'h8, 36'(acks));
		access(1'b0, 23'h000a02, '0);
		check("hit data", {14'h0c3a, 22'h014a02}, eu_data);
		check("hit acks", 36'h0, 36'(acks));
		access(1'b0, 23'h000810, '0);
		check("neighbour data", {14'h0c3a, 22'h016810}, eu_data);
		check("neighbour acks", 36'h4, 36'(acks));
		access(1'b1, 23'h000810, 36'h0);
		check("write fault", 36'he00000810, fault_word_out);
		check("vector", {25'h0, 11'h3ff}, {25'h0, cs_addr});
		access(1'b0, 23'h002005, '0);
		check("access fault", 36'h900002005, fault_word_out);
		access(1'b1, 23'h000a40, 36'h123456789);
		check("stored word", 36'h123456789, rd(22'h014a40));
		access(1'b0, 23'h000a40, '0);
		check("read back", 36'h123456789, eu_data);
		{slow, par_inj} = 2'h3;
		access(1'b0, 23'h000a80, '0);
		{slow, par_inj} = 2'h0;
		check("slow data", {14'h0c3a, 22'h014a80}, eu_data);
		repeat (8) @(negedge core_clk_in);
		check("parity flag", 36'h1, {35'h0, processor_parity_flag_out});
		check("parity irq", 36'h1, {35'h0, err_irq_out});
		err_clr_in = 5'h1f;
		@(negedge core_clk_in);
		err_clr_in = 5'h00;
		// each other error class sets its own flag
		for (int i = 0; i < 4; i++) begin
			mem_err_in = 4'h1 << i;
			@(negedge core_clk_in);
			mem_err_in = 4'h0;
			@(negedge core_clk_in);
			check("flags", {31'h0, 5'h01 << i}, {31'h0, processor_error_flags_out});
			check("irq", 36'h1, {35'h0, err_irq_out});
			err_clr_in = 5'h1f;
			@(negedge core_clk_in);
			err_clr_in = 5'h00;
		end
		walk_user_in = 1'b1;
		walk(5'h03, 13'h0abc, 6'h15, 1'b0, 1'b0);
		walk(5'h04, 13'h0222, 6'h0f, 1'b0, 1'b0);
		walk(5'h05, 13'h0000, 6'h00, 1'b1, 1'b0);
		walk(5'h06, 13'h0abc, 6'h14, 1'b0, 1'b0);
		// abandoned chain re-reads its section pointer: three reads, not two
		walk(5'h03, 13'h0abc, 6'h15, 1'b0, 1'b1);
		check("restart reads", 36'h3, 36'(acks));
		walk_user_in = 1'b0;
		walk(5'h03, 13'h0222, 6'h0f, 1'b0, 1'b0);
		summarize();
	end
endmodule : test_vpt_translate

bind vpt_translate vpt_translate_monitor i_vpt_translate_monitor (.core_clk_in, .rst_n_in,
	.req_valid_in, .req_in, .memory_response_out, .pf_hold_out, .fault_word_out,
	.mem_cmd_out, .mem_ack_in, .mem_err_in, .buffer_parity_fault_out,
	.processor_parity_flag_out, .processor_error_flags_out, .err_irq_out);
